/* File: verilog/vpcr_regs.sv */
// AHB-Lite register bank controlling the voice playback engine.
`timescale 1ns/1ps
module vpcr_regs
	import vpcr_pkg::*;
(
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// AHB-Lite slave port.
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Status from the synthesis datapath.
	input  wire logic        phraseStart,
	input  wire logic        resumeReady,
	// Controls to the synthesis datapath.
	output logic             playEnable,
	output logic             playRun,
	output logic             stopPulse,
	output logic             fifoClear,
	output logic             resultZero,
	output logic      [8:0]  rateDeciKhz,
	output logic             rateValid,
	output logic      [2:0]  formatCode,
	output logic [FMT_COUNT-1:0] formatOneHot,
	output logic             formatValid,
	output logic      [4:0]  hqStopLength,
	output logic      [3:0]  minResumeBytes,
	output logic      [4:0]  appliedVolume,
	output logic             volumeMute
);

	// Register contents.
	logic [7:0]       synFormat;
	logic [VOL_W-1:0] volumeSetting;
	logic             deferSel;
	logic [HQ_W-1:0]  hqLen;
	logic             halted;

	// Bus handler state.
	vpcr_bus_e   busState;
	vpcr_bus_e   next_busState;
	logic [15:0] regIdx;
	logic        addrOk;
	logic        accept;
	logic        wrCtrl;
	logic        wrStop;

	// Maps a byte address onto a register index match.
	function automatic logic hitsReg(input logic [31:0] a, input logic [15:0] idx);
		hitsReg = (a[31:18] == 14'h0000) && (a[17:2] == idx) && (a[1:0] == 2'h0);
	endfunction : hitsReg

	// Decodes the rate field to tenths of a kHz; zero means prohibited.
	function automatic logic [8:0] rateOf(input logic [RATE_W-1:0] code);
		case (code)
			RATE_8K0:  rateOf = DECI_8K0;
			RATE_16K0: rateOf = DECI_16K0;
			RATE_32K0: rateOf = DECI_32K0;
			RATE_10K7: rateOf = DECI_10K7;
			RATE_21K3: rateOf = DECI_21K3;
			RATE_6K4:  rateOf = DECI_6K4;
			RATE_12K8: rateOf = DECI_12K8;
			RATE_25K6: rateOf = DECI_25K6;
			default:   rateOf = 9'h000;
		endcase
	endfunction : rateOf

	// A transfer is taken when selected, non-idle and the bus is ready.
	assign accept = hsel && htrans[1] && hready;
	assign wrCtrl = (busState == BUS_WRITE) && addrOk && (regIdx == IDX_CONTROL);
	assign wrStop = wrCtrl && hwdata[STOP_BIT];

	// Next bus state; writes finish in their data phase, reads wait one cycle.
	always_comb
	begin
		next_busState = BUS_IDLE;
		case (busState)
			BUS_RDWAIT: next_busState = BUS_IDLE;
			BUS_IDLE, BUS_WRITE:
			begin
				if (accept)
					next_busState = hwrite ? BUS_WRITE : BUS_RDWAIT;
			end
			default: next_busState = BUS_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			busState <= BUS_IDLE;
		else
			busState <= next_busState;
	end

	// Address phase capture; unmapped addresses read zero and drop writes.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			regIdx <= 16'h0000;
			addrOk <= 1'b0;
		end
		else if (accept && busState != BUS_RDWAIT)
		begin
			regIdx <= haddr[17:2];
			addrOk <= hitsReg(haddr, haddr[17:2]);
		end
	end

	// The read wait state gives registers one edge to settle after a write.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			hreadyout <= 1'b1;
		else
			hreadyout <= (next_busState != BUS_RDWAIT);
	end

	// Only single word transfers are supported, so every answer is OKAY.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// Read data mux; unused positions come back as zero.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else if (busState == BUS_RDWAIT)
		begin
			hrdata <= 32'h0000_0000;
			if (addrOk)
			begin
				case (regIdx)
					IDX_HQ_STOP_LEN: hrdata[7:HQ_LSB] <= hqLen;
					IDX_MODE:        hrdata[DEFER_BIT] <= deferSel;
					IDX_SYN_FORMAT:  hrdata[6:0] <= synFormat[6:0];
					IDX_VOLUME:      hrdata[VOL_W-1:0] <= volumeSetting;
					IDX_CONTROL:     hrdata[ENABLE_BIT] <= playEnable;
					IDX_VOL_STATUS:  hrdata[VOL_W-1:0] <= deferSel ? appliedVolume
						: volumeSetting;
					default:         hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Format register; bit 7 is unused and never stored.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			synFormat <= RST_SYN_FORMAT;
		else if (busState == BUS_WRITE && addrOk && regIdx == IDX_SYN_FORMAT)
			synFormat <= {1'b0, hwdata[6:0]};
	end

	// Volume register holds five bits only.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			volumeSetting <= RST_VOLUME;
		else if (busState == BUS_WRITE && addrOk && regIdx == IDX_VOLUME)
			volumeSetting <= hwdata[VOL_W-1:0];
	end

	// Deferred volume select in the mode register.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			deferSel <= 1'b0;
		else if (busState == BUS_WRITE && addrOk && regIdx == IDX_MODE)
			deferSel <= hwdata[DEFER_BIT];
	end

	// Phrase stop length for the high quality format.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			hqLen <= RST_HQ_LEN;
		else if (busState == BUS_WRITE && addrOk && regIdx == IDX_HQ_STOP_LEN)
			hqLen <= hwdata[7:HQ_LSB];
	end

	// Enable bit; the stop bit is a strobe and is never stored.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			playEnable <= 1'b0;
		else if (wrCtrl)
			playEnable <= hwdata[ENABLE_BIT];
	end

	// Stop holds playback until the datapath reports enough refill data.
	// The stop strobe wins over a resume seen in the same cycle.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			halted <= 1'b0;
		else if (wrStop)
			halted <= 1'b1;
		else if (resumeReady)
			halted <= 1'b0;
	end

	// One-cycle strobes that flush the FIFO and the synthesis state.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			stopPulse <= 1'b0;
			fifoClear <= 1'b0;
		end
		else
		begin
			stopPulse <= wrStop;
			fifoClear <= wrStop;
		end
	end

	// Run and zero-result levels seen by the datapath.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			playRun    <= 1'b0;
			resultZero <= 1'b1;
		end
		else
		begin
			playRun    <= (wrCtrl ? hwdata[ENABLE_BIT] : playEnable)
				&& !wrStop && !(halted && !resumeReady);
			resultZero <= wrStop || (halted && !resumeReady);
		end
	end

	// Rate decode.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			rateDeciKhz <= DECI_8K0;
			rateValid   <= 1'b1;
		end
		else
		begin
			rateDeciKhz <= rateOf(synFormat[RATE_LSB +: RATE_W]);
			rateValid   <= (rateOf(synFormat[RATE_LSB +: RATE_W]) != 9'h000);
		end
	end

	// Format code, validity and refill threshold.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			formatCode     <= FMT_LPCM16;
			formatValid    <= 1'b1;
			minResumeBytes <= RESUME_BYTES;
			hqStopLength   <= RST_HQ_LEN;
		end
		else
		begin
			formatCode     <= synFormat[FMT_LSB +: FMT_W];
			formatValid    <= (synFormat[FMT_LSB +: FMT_W] >= FMT_ADPCM4)
				&& (synFormat[FMT_LSB +: FMT_W] <= FMT_HQ);
			minResumeBytes <= (synFormat[FMT_LSB +: FMT_W] == FMT_HQ)
				? RESUME_BYTES_HQ : RESUME_BYTES;
			hqStopLength   <= hqLen;
		end
	end

	// One flag per legal format, so the datapath never decodes codes itself.
	genvar g;
	generate
		for (g = 0; g < FMT_COUNT; g++)
		begin : gFmt
			always_ff @(posedge core_clk)
			begin
				if (!rst_n)
					formatOneHot[g] <= (FMT_LPCM16 == 3'(g + 1));
				else
					formatOneHot[g] <= (synFormat[FMT_LSB +: FMT_W] == 3'(g + 1));
			end
		end
	endgenerate

	// Applied volume, immediate or phrase-synchronous.
	vpcr_volume_apply uVol (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.volumeSetting (volumeSetting),
		.deferSel      (deferSel),
		.phraseStart   (phraseStart),
		.appliedVolume (appliedVolume),
		.volumeMute    (volumeMute)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_stop_halts_play: assert property (wrStop |=> stopPulse && fifoClear
		&& resultZero && !playRun) else $error("stop write did not halt playback");
	a_stop_strobe_once: assert property (wrStop ##1 !wrStop |=> !stopPulse)
		else $error("stop strobe longer than one cycle");
	a_enable_stored: assert property (wrCtrl && !hwdata[ENABLE_BIT]
		|=> !playEnable && !playRun) else $error("enable clear did not stop playback");
	a_volume_store: assert property (busState == BUS_WRITE && addrOk && regIdx == IDX_VOLUME
		|=> volumeSetting == $past(hwdata[VOL_W-1:0]))
		else $error("volume write not stored");
	a_status_follow: assert property (busState == BUS_RDWAIT && addrOk && regIdx == IDX_VOL_STATUS
		&& !deferSel |=> hrdata == {27'h0, $past(volumeSetting)})
		else $error("status differs from volume when not deferred");
	a_unused_zero: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
		else $error("unused read bits not zero");
	a_rate_decode: assert property (synFormat[RATE_LSB +: RATE_W] == RATE_25K6
		|=> rateDeciKhz == DECI_25K6 && rateValid)
		else $error("rate decode wrong");
	a_resume_bytes: assert property (synFormat[FMT_LSB +: FMT_W] == FMT_HQ
		|=> minResumeBytes == RESUME_BYTES_HQ)
		else $error("refill threshold wrong for high quality format");
	a_read_wait: assert property (accept && !hwrite && busState != BUS_RDWAIT
		|=> !hreadyout ##1 hreadyout)
		else $error("read did not take exactly one wait state");

	c_stop_write: cover property (wrStop);
	c_deferred_read: cover property (busState == BUS_RDWAIT && regIdx == IDX_VOL_STATUS && deferSel);
	c_resume: cover property (halted ##1 !halted);

endmodule : vpcr_regs

/* File: verilog/vpcr_pkg.sv */
// Constants shared by the voice playback control register bank.
package vpcr_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [15:0] IDX_HQ_STOP_LEN = 16'hf2b2;
	localparam logic [15:0] IDX_MODE        = 16'hf2b4;
	localparam logic [15:0] IDX_SYN_FORMAT  = 16'hf2b5;
	localparam logic [15:0] IDX_VOLUME      = 16'hf2b6;
	localparam logic [15:0] IDX_CONTROL     = 16'hf2b7;
	localparam logic [15:0] IDX_VOL_STATUS  = 16'hf2c0;

	// Field positions.
	localparam int RATE_LSB   = 0;
	localparam int RATE_W     = 4;
	localparam int FMT_LSB    = 4;
	localparam int FMT_W      = 3;
	localparam int VOL_W      = 5;
	localparam int HQ_LSB     = 3;
	localparam int HQ_W       = 5;
	localparam int DEFER_BIT  = 7;
	localparam int ENABLE_BIT = 0;
	localparam int STOP_BIT   = 4;

	// Reset values.
	localparam logic [7:0] RST_SYN_FORMAT = 8'h41;
	localparam logic [4:0] RST_VOLUME     = 5'h09;
	localparam logic [4:0] RST_HQ_LEN     = 5'h00;

	// Rate codes and rates in units of 0.1 kHz.
	localparam logic [3:0] RATE_8K0  = 4'h1;
	localparam logic [3:0] RATE_16K0 = 4'h2;
	localparam logic [3:0] RATE_32K0 = 4'h3;
	localparam logic [3:0] RATE_10K7 = 4'h5;
	localparam logic [3:0] RATE_21K3 = 4'h6;
	localparam logic [3:0] RATE_6K4  = 4'h8;
	localparam logic [3:0] RATE_12K8 = 4'h9;
	localparam logic [3:0] RATE_25K6 = 4'ha;
	localparam logic [8:0] DECI_8K0  = 9'h050;
	localparam logic [8:0] DECI_16K0 = 9'h0a0;
	localparam logic [8:0] DECI_32K0 = 9'h140;
	localparam logic [8:0] DECI_10K7 = 9'h06b;
	localparam logic [8:0] DECI_21K3 = 9'h0d5;
	localparam logic [8:0] DECI_6K4  = 9'h040;
	localparam logic [8:0] DECI_12K8 = 9'h080;
	localparam logic [8:0] DECI_25K6 = 9'h100;

	// Synthesis format codes.
	localparam logic [2:0] FMT_ADPCM4  = 3'h1;
	localparam logic [2:0] FMT_NLPCM8  = 3'h2;
	localparam logic [2:0] FMT_LPCM8   = 3'h3;
	localparam logic [2:0] FMT_LPCM16  = 3'h4;
	localparam logic [2:0] FMT_HQ      = 3'h5;
	localparam int         FMT_COUNT   = 5;

	// Volume codes and refill thresholds.
	localparam logic [4:0] VOL_MUTE       = 5'h1f;
	localparam logic [3:0] RESUME_BYTES   = 4'h4;
	localparam logic [3:0] RESUME_BYTES_HQ = 4'hc;

	// Bus handler states, Gray along idle to read wait.
	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_RDWAIT = 2'b01,
		BUS_WRITE  = 2'b10
	} vpcr_bus_e;

endpackage : vpcr_pkg

/* File: verilog/vpcr_volume_apply.sv */
// Applied-volume holder with immediate or phrase-synchronous update.
`timescale 1ns/1ps
module vpcr_volume_apply
	import vpcr_pkg::*;
(
	// Clock and reset.
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// Settings from the register bank.
	input  wire logic [VOL_W-1:0] volumeSetting,
	input  wire logic             deferSel,
	input  wire logic             phraseStart,
	// Volume in effect.
	output logic      [VOL_W-1:0] appliedVolume,
	output logic                  volumeMute
);

	// In deferred mode the code only moves when a phrase begins.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			appliedVolume <= RST_VOLUME;
		else if (!deferSel || phraseStart)
			appliedVolume <= volumeSetting;
	end

	// Mute follows the code in effect, updating on the same edge as appliedVolume.
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			volumeMute <= 1'b0;
		else if (!deferSel || phraseStart)
			volumeMute <= (volumeSetting == VOL_MUTE);
	end

	default clocking cbv @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_defer_hold: assert property (deferSel && !phraseStart |=> $stable(appliedVolume))
		else $error("applied volume moved while deferred");
	a_phrase_latch: assert property (phraseStart |=> appliedVolume == $past(volumeSetting))
		else $error("volume not latched at phrase start");
	c_defer_latch: cover property (deferSel && phraseStart);

endmodule : vpcr_volume_apply

/* File: dv/vpcr_tb.sv */
// Self-checking testbench for the voice playback control register bank.
`timescale 1ns/1ps
module tb
	import vpcr_pkg::*;
;
	// Bus side of the bench.
	logic        core_clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hready;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	// Datapath side of the bench.
	logic        phraseStart;
	logic        resumeReady;
	logic        playEnable;
	logic        playRun;
	logic        stopPulse;
	logic        fifoClear;
	logic        resultZero;
	logic [8:0]  rateDeciKhz;
	logic        rateValid;
	logic [2:0]  formatCode;
	logic [4:0]  formatOneHot;
	logic        formatValid;
	logic [4:0]  hqStopLength;
	logic [3:0]  minResumeBytes;
	logic [4:0]  appliedVolume;
	logic        volumeMute;
	int          fails;
	int          n_checks;

	// The single slave's ready is the bus ready.
	assign hready = hreadyout;

	vpcr_regs DUT (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phraseStart(phraseStart),
		.resumeReady(resumeReady), .playEnable(playEnable), .playRun(playRun),
		.stopPulse(stopPulse), .fifoClear(fifoClear), .resultZero(resultZero),
		.rateDeciKhz(rateDeciKhz), .rateValid(rateValid), .formatCode(formatCode),
		.formatOneHot(formatOneHot), .formatValid(formatValid), .hqStopLength(hqStopLength),
		.minResumeBytes(minResumeBytes), .appliedVolume(appliedVolume),
		.volumeMute(volumeMute));

	// Free-running 25 MHz clock.
	initial
	begin
		core_clk = 1'h0;
		forever #20 core_clk = ~core_clk;
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// One single AHB-Lite transfer; the master waits for ready rather than counting cycles.
	task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge core_clk);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {14'h0000, idx, 2'h0};
		do @(posedge core_clk); while (hready !== 1'h1);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do @(posedge core_clk); while (hready !== 1'h1);
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : bus

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'h1, idx, d, q);
	endtask : wr

	task automatic rdc(input string nm, input logic [15:0] idx, input logic [7:0] e);
		logic [31:0] q;
		bus(1'h0, idx, 8'h00, q);
		chk(nm, {24'h000000, e}, q);
	endtask : rdc

	// Derived outputs follow a register write by one edge; waiting two edges leaves a margin.
	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle

	task automatic t_reset();
		rdc("format reset", IDX_SYN_FORMAT, 8'h41);
		rdc("volume reset", IDX_VOLUME, 8'h09);
		rdc("control reset", IDX_CONTROL, 8'h00);
		rdc("stop length reset", IDX_HQ_STOP_LEN, 8'h00);
		rdc("status reset", IDX_VOL_STATUS, 8'h09);
		chk("rate after reset", 32'h50, rateDeciKhz);
		chk("format after reset", 32'h4, formatCode);
		chk("volume after reset", 32'h9, appliedVolume);
	endtask : t_reset

	// Every legal rate code, then some prohibited ones, which must be flagged.
	task automatic t_rates();
		logic [3:0] codes [11] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha,
			4'h0, 4'h4, 4'hc};
		logic [8:0] deci [11] = '{9'h050, 9'h0a0, 9'h140, 9'h06b, 9'h0d5, 9'h040, 9'h080,
			9'h100, 9'h000, 9'h000, 9'h000};
		for (int i = 0; i < 11; i++)
		begin
			wr(IDX_SYN_FORMAT, {4'h4, codes[i]});
			settle();
			chk("rate", deci[i], rateDeciKhz);
			chk("rate valid", i < 8, rateValid);
		end
	endtask : t_rates

	// All eight format codes, legal and prohibited, plus the unused top bit.
	task automatic t_formats();
		for (int f = 0; f < 8; f++)
		begin
			wr(IDX_SYN_FORMAT, {1'h0, 3'(f), 4'h1});
			settle();
			chk("format code", f, formatCode);
			chk("format valid", f >= 1 && f <= 5, formatValid);
			if (f >= 1 && f <= 5)
			begin
				chk("format one hot", 32'h1 << (f - 1), formatOneHot);
				chk("resume bytes", (f == 5) ? 12 : 4, minResumeBytes);
			end
		end
		wr(IDX_SYN_FORMAT, 8'hc1);
		rdc("format unused bit", IDX_SYN_FORMAT, 8'h41);
	endtask : t_formats

	// Volume extremes, mute code and immediate status readback.
	task automatic t_volume();
		wr(IDX_VOLUME, 8'hff);
		settle();
		rdc("volume unused bits", IDX_VOLUME, 8'h1f);
		chk("mute", 32'h1, volumeMute);
		rdc("status follows", IDX_VOL_STATUS, 8'h1f);
		wr(IDX_VOLUME, 8'h1e);
		settle();
		chk("quietest volume", 32'h1e, appliedVolume);
		chk("no mute", 32'h0, volumeMute);
		wr(IDX_VOLUME, 8'h00);
		settle();
		chk("loudest volume", 32'h0, appliedVolume);
		wr(IDX_VOLUME, 8'h09);
		settle();
	endtask : t_volume

	// Deferred volume waits for a phrase start, then immediate mode resumes.
	task automatic t_defer();
		wr(IDX_MODE, 8'h80);
		rdc("mode", IDX_MODE, 8'h80);
		wr(IDX_VOLUME, 8'h05);
		settle();
		chk("volume held", 32'h9, appliedVolume);
		rdc("status held", IDX_VOL_STATUS, 8'h09);
		@(posedge core_clk);
		phraseStart <= 1'h1;
		@(posedge core_clk);
		phraseStart <= 1'h0;
		settle();
		chk("volume latched", 32'h5, appliedVolume);
		rdc("status latched", IDX_VOL_STATUS, 8'h05);
		wr(IDX_MODE, 8'h00);
		wr(IDX_VOLUME, 8'h07);
		settle();
		chk("volume immediate", 32'h7, appliedVolume);
	endtask : t_defer

	// Stop strobe during playback: one pulse, hold until refilled, strobe reads zero.
	task automatic t_stop();
		int sp;
		int fc;
		sp = 0;
		fc = 0;
		@(posedge core_clk);
		resumeReady <= 1'h1;
		wr(IDX_CONTROL, 8'h01);
		settle();
		chk("enable", 32'h1, playEnable);
		chk("running", 32'h1, playRun);
		chk("result free", 32'h0, resultZero);
		@(posedge core_clk);
		resumeReady <= 1'h0;
		wr(IDX_CONTROL, 8'h11);
		repeat (6)
		begin
			#1;
			sp += (stopPulse === 1'h1);
			fc += (fifoClear === 1'h1);
			@(posedge core_clk);
		end
		chk("stop pulses", 32'h1, sp);
		chk("fifo clears", 32'h1, fc);
		#1;
		chk("halted", 32'h0, playRun);
		chk("result forced", 32'h1, resultZero);
		rdc("stop bit reads zero", IDX_CONTROL, 8'h01);
		@(posedge core_clk);
		resumeReady <= 1'h1;
		settle();
		chk("resumed", 32'h1, playRun);
		chk("result released", 32'h0, resultZero);
		wr(IDX_CONTROL, 8'h00);
		settle();
		chk("disabled", 32'h0, playEnable);
		chk("stopped", 32'h0, playRun);
	endtask : t_stop

	// Stop length field, a read-only register and an unmapped word.
	task automatic t_misc();
		wr(IDX_HQ_STOP_LEN, 8'hff);
		settle();
		rdc("stop length", IDX_HQ_STOP_LEN, 8'hf8);
		chk("stop length out", 32'h1f, hqStopLength);
		wr(IDX_HQ_STOP_LEN, 8'h50);
		settle();
		chk("stop length out", 32'h0a, hqStopLength);
		wr(IDX_VOL_STATUS, 8'h1f);
		rdc("status read only", IDX_VOL_STATUS, 8'h07);
		wr(16'hf2b3, 8'hff);
		rdc("unmapped", 16'hf2b3, 8'h00);
	endtask : t_misc

	// Main sequence: reset for ten cycles, then every scenario in turn.
	initial
	begin
		fails       = 0;
		n_checks    = 0;
		rst_n       = 1'h0;
		hsel        = 1'h0;
		haddr       = 32'h0;
		htrans      = 2'h0;
		hwrite      = 1'h0;
		hsize       = 3'h2;
		hwdata      = 32'h0;
		phraseStart = 1'h0;
		resumeReady = 1'h0;
		repeat (10) @(posedge core_clk);
		rst_n <= 1'h1;
		t_reset();
		t_rates();
		t_formats();
		t_volume();
		t_defer();
		t_stop();
		t_misc();
		wrap_up();
	end

	// Watchdog: the whole run needs a few hundred cycles, so this only cuts a hang.
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fails++;
		wrap_up();
	end
endmodule : tb
